// ===== verilog/trim_regs_pkg.sv
/*
 * Constants and types shared by the sampling timing and offset trim bank.
 * Assumes byte-wide register access at the printed byte addresses.
 */
package trim_regs_pkg;

    // ========================================================================
    // Widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int TRIM_W = 8;
    localparam int OFS_W = 12;
    localparam int OFS_REG_W = 16;
    localparam int OFS_HI_BITS = OFS_W - DATA_W;
    localparam int OFS_RSVD_W = OFS_REG_W - OFS_W;
    localparam int NUM_TIMING = 4;

    // ========================================================================
    // Register byte addresses
    localparam logic [ADDR_W-1:0] TIMING_BASE_ADDR = 12'h086;
    localparam logic [ADDR_W-1:0] ADDR_TIMING_A = 12'h086;
    localparam logic [ADDR_W-1:0] ADDR_TIMING_CA = 12'h087;
    localparam logic [ADDR_W-1:0] ADDR_TIMING_CB = 12'h088;
    localparam logic [ADDR_W-1:0] ADDR_TIMING_B = 12'h089;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_LO = 12'h08a;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET_HI = 12'h08b;

    // ========================================================================
    // Timing trim array slots, in address order
    localparam int IDX_A = 0;
    localparam int IDX_CA = 1;
    localparam int IDX_CB = 2;
    localparam int IDX_B = 3;

    // ========================================================================
    // Reset and idle values
    localparam logic [OFS_RSVD_W-1:0] OFS_RSVD_RESET = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [TRIM_W-1:0] TRIM_ZERO = 8'h00;
    localparam logic [OFS_W-1:0] OFS_ZERO = 12'h000;

    // ========================================================================
    // Role of core C in dual-channel mode
    typedef enum logic [1:0] {
        CORE_C_IDLE,
        CORE_C_FOR_A,
        CORE_C_FOR_B
    } core_c_role_t;

endpackage

// ===== verilog/trim_route.sv
/*
 * Routes the stored trims to the converter cores for the present mode.
 * Assumes mode and input selection come from logic on the same clock.
 */
`timescale 1ns/10ps
module trim_route
    import trim_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Mode
    input wire logic dual_mode_in,
    input core_c_role_t core_c_role_in,
    input wire logic core_a_on_input_a_in,
    // Stored trims
    input wire logic [TRIM_W-1:0] timing_a_in,
    input wire logic [TRIM_W-1:0] timing_ca_in,
    input wire logic [TRIM_W-1:0] timing_cb_in,
    input wire logic [TRIM_W-1:0] timing_b_in,
    input wire logic [OFS_W-1:0] offset_a_in,
    // Trims to the cores
    output logic [TRIM_W-1:0] core_a_timing_out,
    output logic [TRIM_W-1:0] core_b_timing_out,
    output logic [TRIM_W-1:0] core_c_timing_out,
    output logic timing_apply_out,
    output logic core_c_apply_out,
    output logic [OFS_W-1:0] offset_core_a_out,
    output logic offset_apply_out
);

    // ========================================================================
    // Dual-channel timing trims for cores A and B
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !dual_mode_in) begin
            core_a_timing_out <= TRIM_ZERO; // R2
            core_b_timing_out <= TRIM_ZERO;
            timing_apply_out <= 1'b0;
        end else begin
            core_a_timing_out <= timing_a_in; // R1
            core_b_timing_out <= timing_b_in; // R2
            timing_apply_out <= 1'b1;
        end
    end

    // ========================================================================
    // Core C takes its own trim for the core it stands in for (C-for-A or C-for-B)
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !dual_mode_in) begin
            core_c_timing_out <= TRIM_ZERO;
            core_c_apply_out <= 1'b0;
        end else begin
            case (core_c_role_in)
                CORE_C_FOR_A: begin
                    core_c_timing_out <= timing_ca_in; // R2
                    core_c_apply_out <= 1'b1;
                end
                CORE_C_FOR_B: begin
                    core_c_timing_out <= timing_cb_in; // R2
                    core_c_apply_out <= 1'b1;
                end
                default: begin
                    core_c_timing_out <= TRIM_ZERO;
                    core_c_apply_out <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================================
    // Offset trim for core A on input A only
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !core_a_on_input_a_in) begin
            offset_core_a_out <= OFS_ZERO;
            offset_apply_out <= 1'b0;
        end else begin
            offset_core_a_out <= offset_a_in; // R10
            offset_apply_out <= 1'b1; // R10
        end
    end

    // ========================================================================
    // Checks
    property p_core_c_for_a;
        @(posedge clk_in) disable iff (sys_rst_in)
        (dual_mode_in && core_c_role_in == CORE_C_FOR_A) |=>
            (core_c_apply_out && core_c_timing_out == $past(timing_ca_in));
    endproperty
    a_core_c_for_a: assert property (p_core_c_for_a) // R2
        else $error("core C did not take its stand-in trim for A");

    property p_core_c_for_b;
        @(posedge clk_in) disable iff (sys_rst_in)
        (dual_mode_in && core_c_role_in == CORE_C_FOR_B) |=>
            (core_c_apply_out && core_c_timing_out == $past(timing_cb_in));
    endproperty
    a_core_c_for_b: assert property (p_core_c_for_b) // R2
        else $error("core C did not take its stand-in trim for B");

    property p_single_mode_no_trim;
        @(posedge clk_in) disable iff (sys_rst_in)
        !dual_mode_in |=> (!timing_apply_out && !core_c_apply_out);
    endproperty
    a_single_mode_no_trim: assert property (p_single_mode_no_trim) // R2
        else $error("dual-channel trims applied outside dual mode");

    property p_offset_apply;
        @(posedge clk_in) disable iff (sys_rst_in)
        offset_apply_out |->
            ($past(core_a_on_input_a_in) &&
             offset_core_a_out == $past(offset_a_in));
    endproperty
    a_offset_apply: assert property (p_offset_apply) // R10
        else $error("offset trim applied while core A not on input A");

endmodule // trim_route

// ===== verilog/sample_timing_offset_trim_regs.sv
/*
 * Register bank for dual-channel timing trims and core A input A offset.
 * Assumes factory trim values and calibration status are on the same clock.
 */
// Implementation choice: the strobed register port.
// Functional notes
// (R1) Each timing trim is an 8-bit read/write field setting one sample instant.
// (R2) Dual mode: separate trims for A, C-for-A, C-for-B, B; each own case.
// (R3) Trims load factory values at reset; software reads and overwrites them.
// (R4) Offset trim is 12-bit unsigned in bits 11:0 over two byte addresses.
// (R5) Offset register bits 15:12 are reserved, read/write, reset to zero.
// (R6) Host never writes offset trims during foreground calibration.
// (R7) Host never writes offset trims with both background enables set.
// (R8) Offset cal on, background offset off: read only after foreground done.
// (R9) Both background enables set: read only while calibration halted.
// (R10) Core A offset trim applies only while core A samples input A.
`timescale 1ns/10ps
module sample_timing_offset_trim_regs
    import trim_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    // Factory trim values
    input wire logic [TRIM_W-1:0] factory_timing_a_in,
    input wire logic [TRIM_W-1:0] factory_timing_ca_in,
    input wire logic [TRIM_W-1:0] factory_timing_cb_in,
    input wire logic [TRIM_W-1:0] factory_timing_b_in,
    input wire logic [OFS_W-1:0] factory_offset_in,
    // Calibration status
    input wire logic fg_cal_active_in,
    input wire logic background_cal_enable_in,
    input wire logic background_offset_cal_enable_in,
    input wire logic offset_cal_enable_in,
    input wire logic foreground_cal_done_in,
    input wire logic calibration_halted_flag_in,
    // Mode
    input wire logic dual_mode_in,
    input core_c_role_t core_c_role_in,
    input wire logic core_a_on_input_a_in,
    // Trims to the cores
    output logic [TRIM_W-1:0] core_a_timing_out,
    output logic [TRIM_W-1:0] core_b_timing_out,
    output logic [TRIM_W-1:0] core_c_timing_out,
    output logic timing_apply_out,
    output logic core_c_apply_out,
    output logic [OFS_W-1:0] offset_core_a_out,
    output logic offset_apply_out,
    // Access windows
    output logic offset_write_safe_out,
    output logic offset_read_safe_out
);

    // ========================================================================
    // Address decode
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] target);
        addr_hit = (addr == target);
    endfunction

    logic [TRIM_W-1:0] timing_q [NUM_TIMING];
    logic [TRIM_W-1:0] factory_timing [NUM_TIMING];
    logic [OFS_REG_W-1:0] offset_q;
    logic [DATA_W-1:0] rd_mux_d;

    assign factory_timing[IDX_A] = factory_timing_a_in;
    assign factory_timing[IDX_CA] = factory_timing_ca_in;
    assign factory_timing[IDX_CB] = factory_timing_cb_in;
    assign factory_timing[IDX_B] = factory_timing_b_in;

    // ========================================================================
    // Timing trim registers
    genvar g;
    generate
        for (g = 0; g < NUM_TIMING; g++) begin : gen_timing
            localparam logic [ADDR_W-1:0] SLOT_ADDR =
                TIMING_BASE_ADDR + ADDR_W'(g);
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    timing_q[g] <= factory_timing[g]; // R3
                end else if (reg_wr_in && addr_hit(reg_addr_in, SLOT_ADDR)) begin
                    timing_q[g] <= reg_wdata_in; // R1
                end
            end
        end
    endgenerate

    // ========================================================================
    // Offset trim register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            offset_q <= {OFS_RSVD_RESET, factory_offset_in}; // R3 R5
        end else if (reg_wr_in && addr_hit(reg_addr_in, ADDR_OFFSET_LO)) begin
            offset_q[DATA_W-1:0] <= reg_wdata_in; // R4
        end else if (reg_wr_in && addr_hit(reg_addr_in, ADDR_OFFSET_HI)) begin
            offset_q[OFS_REG_W-1:DATA_W] <= reg_wdata_in; // R4 R5
        end
    end

    // ========================================================================
    // Read path
    always_comb begin
        rd_mux_d = READ_ZERO;
        if (addr_hit(reg_addr_in, ADDR_TIMING_A)) begin
            rd_mux_d = timing_q[IDX_A];
        end else if (addr_hit(reg_addr_in, ADDR_TIMING_CA)) begin
            rd_mux_d = timing_q[IDX_CA];
        end else if (addr_hit(reg_addr_in, ADDR_TIMING_CB)) begin
            rd_mux_d = timing_q[IDX_CB];
        end else if (addr_hit(reg_addr_in, ADDR_TIMING_B)) begin
            rd_mux_d = timing_q[IDX_B];
        end else if (addr_hit(reg_addr_in, ADDR_OFFSET_LO)) begin
            rd_mux_d = offset_q[DATA_W-1:0]; // R4
        end else if (addr_hit(reg_addr_in, ADDR_OFFSET_HI)) begin
            rd_mux_d = offset_q[OFS_REG_W-1:DATA_W]; // R5
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !reg_rd_in) begin
            reg_rdata_out <= READ_ZERO;
        end else begin
            reg_rdata_out <= rd_mux_d; // R3
        end
    end

    // ========================================================================
    // Offset access windows shown to the host
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            offset_write_safe_out <= 1'b0;
            offset_read_safe_out <= 1'b0;
        end else begin
            offset_write_safe_out <= !fg_cal_active_in && // R6
                !(background_cal_enable_in &&
                  background_offset_cal_enable_in); // R7
            if (offset_cal_enable_in && !background_offset_cal_enable_in) begin
                offset_read_safe_out <= foreground_cal_done_in; // R8
            end else if (background_cal_enable_in &&
                         background_offset_cal_enable_in) begin
                offset_read_safe_out <= calibration_halted_flag_in; // R9
            end else begin
                offset_read_safe_out <= 1'b1;
            end
        end
    end

    // ========================================================================
    // Trim routing to the cores
    trim_route u_route (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .dual_mode_in(dual_mode_in),
        .core_c_role_in(core_c_role_in),
        .core_a_on_input_a_in(core_a_on_input_a_in),
        .timing_a_in(timing_q[IDX_A]),
        .timing_ca_in(timing_q[IDX_CA]),
        .timing_cb_in(timing_q[IDX_CB]),
        .timing_b_in(timing_q[IDX_B]),
        .offset_a_in(offset_q[OFS_W-1:0]),
        .core_a_timing_out(core_a_timing_out),
        .core_b_timing_out(core_b_timing_out),
        .core_c_timing_out(core_c_timing_out),
        .timing_apply_out(timing_apply_out),
        .core_c_apply_out(core_c_apply_out),
        .offset_core_a_out(offset_core_a_out),
        .offset_apply_out(offset_apply_out)
    );

    // ========================================================================
    // Checks
    sequence s_wr_timing_a;
        reg_wr_in && reg_addr_in == ADDR_TIMING_A;
    endsequence

    sequence s_rd_timing_a;
        reg_rd_in && reg_addr_in == ADDR_TIMING_A;
    endsequence

    property p_write_then_read_a;
        @(posedge clk_in) disable iff (sys_rst_in)
        s_wr_timing_a ##1 s_rd_timing_a |=>
            reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_write_then_read_a: assert property (p_write_then_read_a) // R1
        else $error("timing trim A did not read back its written value");

    property p_write_cb;
        @(posedge clk_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == ADDR_TIMING_CB) |=>
            timing_q[IDX_CB] == $past(reg_wdata_in);
    endproperty
    a_write_cb: assert property (p_write_cb) // R2
        else $error("C-for-B timing trim not written");

    property p_factory_load;
        @(posedge clk_in)
        sys_rst_in |=> (timing_q[IDX_B] == $past(factory_timing_b_in) &&
                        offset_q[OFS_W-1:0] == $past(factory_offset_in));
    endproperty
    a_factory_load: assert property (p_factory_load) // R3
        else $error("factory trim not loaded at reset");

    property p_offset_lo_write;
        @(posedge clk_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == ADDR_OFFSET_LO) |=>
            (offset_q[DATA_W-1:0] == $past(reg_wdata_in) &&
             $stable(offset_q[OFS_REG_W-1:DATA_W]));
    endproperty
    a_offset_lo_write: assert property (p_offset_lo_write) // R4
        else $error("offset trim low byte write wrong");

    property p_offset_hi_read;
        @(posedge clk_in) disable iff (sys_rst_in)
        (reg_rd_in && reg_addr_in == ADDR_OFFSET_HI && !reg_wr_in) |=>
            reg_rdata_out == $past(offset_q[OFS_REG_W-1:DATA_W]);
    endproperty
    a_offset_hi_read: assert property (p_offset_hi_read) // R4
        else $error("offset trim high byte read wrong");

    property p_rsvd_reset;
        @(posedge clk_in)
        sys_rst_in |=> offset_q[OFS_REG_W-1:OFS_W] == OFS_RSVD_RESET;
    endproperty
    a_rsvd_reset: assert property (p_rsvd_reset) // R5
        else $error("reserved offset bits not zero after reset");

    property p_rsvd_write;
        @(posedge clk_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == ADDR_OFFSET_HI) |=>
            offset_q[OFS_REG_W-1:OFS_W] ==
                $past(reg_wdata_in[DATA_W-1:OFS_HI_BITS]);
    endproperty
    a_rsvd_write: assert property (p_rsvd_write) // R5
        else $error("reserved offset bits not writable");

    property p_write_window;
        @(posedge clk_in) disable iff (sys_rst_in)
        (fg_cal_active_in || (background_cal_enable_in &&
                              background_offset_cal_enable_in)) |=>
            !offset_write_safe_out;
    endproperty
    a_write_window: assert property (p_write_window) // R6
        else $error("offset write shown safe during calibration");

    property p_read_window;
        @(posedge clk_in) disable iff (sys_rst_in)
        (offset_cal_enable_in && !background_offset_cal_enable_in &&
         !foreground_cal_done_in) |=> !offset_read_safe_out;
    endproperty
    a_read_window: assert property (p_read_window) // R8
        else $error("offset read shown safe before foreground done");

    property p_idle_read_zero;
        @(posedge clk_in) disable iff (sys_rst_in)
        !reg_rd_in |=> reg_rdata_out == READ_ZERO;
    endproperty
    a_idle_read_zero: assert property (p_idle_read_zero) // R1
        else $error("read data not zero outside the read answer cycle");

endmodule // sample_timing_offset_trim_regs

// ===== testbench/sample_timing_offset_trim_regs_tb_top.sv
/*
 * Self-checking bench for the timing and offset trim register bank.
 * Assumes trim_regs_pkg and the bank's design files are compiled first.
 */
`timescale 1ns/10ps
module sample_timing_offset_trim_regs_tb_top
    import trim_regs_pkg::*;
;
    // ========================================================================
    // Signals
    logic clk_in;
    logic sys_rst_in;
    logic [ADDR_W-1:0] reg_addr_in;
    logic [DATA_W-1:0] reg_wdata_in;
    logic reg_wr_in;
    logic reg_rd_in;
    logic [DATA_W-1:0] reg_rdata_out;
    logic [TRIM_W-1:0] fac_t [NUM_TIMING];
    logic [OFS_W-1:0] fac_o;
    logic [TRIM_W-1:0] pat [NUM_TIMING];
    logic fg_cal_active_in;
    logic background_cal_enable_in;
    logic background_offset_cal_enable_in;
    logic offset_cal_enable_in;
    logic foreground_cal_done_in;
    logic calibration_halted_flag_in;
    logic dual_mode_in;
    core_c_role_t core_c_role_in;
    logic core_a_on_input_a_in;
    logic [TRIM_W-1:0] core_a_timing_out;
    logic [TRIM_W-1:0] core_b_timing_out;
    logic [TRIM_W-1:0] core_c_timing_out;
    logic timing_apply_out;
    logic core_c_apply_out;
    logic [OFS_W-1:0] offset_core_a_out;
    logic offset_apply_out;
    logic offset_write_safe_out;
    logic offset_read_safe_out;
    int bad_count = 0;
    int n_compared = 0;

    // ========================================================================
    // Design under test
    sample_timing_offset_trim_regs DUT (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .factory_timing_a_in(fac_t[IDX_A]),
        .factory_timing_ca_in(fac_t[IDX_CA]),
        .factory_timing_cb_in(fac_t[IDX_CB]),
        .factory_timing_b_in(fac_t[IDX_B]),
        .factory_offset_in(fac_o),
        .fg_cal_active_in(fg_cal_active_in),
        .background_cal_enable_in(background_cal_enable_in),
        .background_offset_cal_enable_in(background_offset_cal_enable_in),
        .offset_cal_enable_in(offset_cal_enable_in),
        .foreground_cal_done_in(foreground_cal_done_in),
        .calibration_halted_flag_in(calibration_halted_flag_in),
        .dual_mode_in(dual_mode_in),
        .core_c_role_in(core_c_role_in),
        .core_a_on_input_a_in(core_a_on_input_a_in),
        .core_a_timing_out(core_a_timing_out),
        .core_b_timing_out(core_b_timing_out),
        .core_c_timing_out(core_c_timing_out),
        .timing_apply_out(timing_apply_out),
        .core_c_apply_out(core_c_apply_out),
        .offset_core_a_out(offset_core_a_out),
        .offset_apply_out(offset_apply_out),
        .offset_write_safe_out(offset_write_safe_out),
        .offset_read_safe_out(offset_read_safe_out)
    );

    // ========================================================================
    // Clock and watchdog
    always #25 clk_in = ~clk_in;

    initial begin
        #200000;
        bad_count++;
        close_out();
    end

    // ========================================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        check(16'(reg_rdata_out), 16'(e));
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_reset_values();
        for (int i = 0; i < NUM_TIMING; i++) begin
            rdchk(TIMING_BASE_ADDR + ADDR_W'(i), fac_t[i]);
        end
        rdchk(ADDR_OFFSET_LO, fac_o[7:0]);
        rdchk(ADDR_OFFSET_HI, {OFS_RSVD_RESET, fac_o[11:8]});
    endtask

    task automatic t_rw_timing();
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= ADDR_TIMING_A;
        reg_wdata_in <= 8'hc4;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        check(16'(reg_rdata_out), 16'h00c4);
        for (int i = 0; i < NUM_TIMING; i++) begin
            wr(TIMING_BASE_ADDR + ADDR_W'(i), pat[i]);
            rdchk(TIMING_BASE_ADDR + ADDR_W'(i), pat[i]);
        end
        @(posedge clk_in);
        #1;
        check(16'(reg_rdata_out), 16'h0000);
        wr(12'h08c, 8'hff);
        wr(12'h186, 8'h77);
        rdchk(12'h08c, 8'h00);
        rdchk(12'h085, 8'h00);
        rdchk(12'h186, 8'h00);
        rdchk(ADDR_TIMING_A, pat[IDX_A]);
    endtask

    task automatic t_offset();
        wr(ADDR_OFFSET_LO, 8'h6d);
        wr(ADDR_OFFSET_HI, 8'hf2);
        rdchk(ADDR_OFFSET_LO, 8'h6d);
        rdchk(ADDR_OFFSET_HI, 8'hf2);
        wr(ADDR_OFFSET_LO, 8'h93);
        rdchk(ADDR_OFFSET_HI, 8'hf2);
    endtask

    task automatic t_route();
        logic dm;
        logic [TRIM_W-1:0] ec;
        core_c_role_t rl;
        for (int m = 0; m < 12; m++) begin
            @(posedge clk_in);
            dual_mode_in <= m[0];
            core_a_on_input_a_in <= m[1];
            core_c_role_in <= core_c_role_t'(m / 4);
            @(posedge clk_in);
            #1;
            dm = m[0];
            rl = core_c_role_t'(m / 4);
            ec = !dm ? TRIM_ZERO : (rl == CORE_C_FOR_A) ? pat[IDX_CA] :
                (rl == CORE_C_FOR_B) ? pat[IDX_CB] : TRIM_ZERO;
            check(16'(core_a_timing_out), dm ? 16'(pat[IDX_A]) : 16'h0);
            check(16'(core_b_timing_out), dm ? 16'(pat[IDX_B]) : 16'h0);
            check(16'(core_c_timing_out), 16'(ec));
            check(16'({timing_apply_out, core_c_apply_out}),
                16'({dm, dm && rl != CORE_C_IDLE}));
            check(16'(offset_core_a_out), m[1] ? 16'h0293 : 16'h0);
            check(16'(offset_apply_out), 16'(m[1]));
        end
        wr(ADDR_TIMING_CB, 8'h3e);
        @(posedge clk_in);
        #1;
        check(16'(core_c_timing_out), 16'h003e);
    endtask

    task automatic t_safe();
        for (int k = 0; k < 64; k++) begin
            @(posedge clk_in);
            {fg_cal_active_in, background_cal_enable_in,
                background_offset_cal_enable_in, offset_cal_enable_in,
                foreground_cal_done_in, calibration_halted_flag_in} <= 6'(k);
            @(posedge clk_in);
            #1;
            check(16'(offset_write_safe_out),
                16'(!k[5] && !(k[4] && k[3])));
            check(16'(offset_read_safe_out), 16'((k[2] && !k[3]) ? k[1] :
                (k[4] && k[3]) ? k[0] : 1'b1));
        end
        @(posedge clk_in);
        {fg_cal_active_in, background_cal_enable_in,
            background_offset_cal_enable_in, offset_cal_enable_in,
            foreground_cal_done_in, calibration_halted_flag_in} <= '0;
    endtask

    task automatic t_second_reset();
        wr(ADDR_OFFSET_HI, 8'hff);
        @(posedge clk_in);
        for (int i = 0; i < NUM_TIMING; i++) begin
            fac_t[i] <= ~fac_t[i];
        end
        fac_o <= 12'h5c1;
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset_values();
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        clk_in = 1'b0;
        sys_rst_in = 1'b1;
        reg_addr_in = '0;
        reg_wdata_in = '0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        fac_t = '{8'h3c, 8'hc3, 8'ha5, 8'h7e};
        fac_o = 12'h9e7;
        pat = '{8'hff, 8'h00, 8'h5a, 8'h81};
        fg_cal_active_in = 1'b0;
        background_cal_enable_in = 1'b0;
        background_offset_cal_enable_in = 1'b0;
        offset_cal_enable_in = 1'b0;
        foreground_cal_done_in = 1'b0;
        calibration_halted_flag_in = 1'b0;
        dual_mode_in = 1'b0;
        core_c_role_in = CORE_C_IDLE;
        core_a_on_input_a_in = 1'b0;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset_values();
        t_rw_timing();
        t_offset();
        t_route();
        t_safe();
        t_second_reset();
        close_out();
    end

endmodule // sample_timing_offset_trim_regs_tb_top
